// ==== sswd_pkg.sv ====
// constants, option tables and register map of the supply supervisor
// assumes a single 40 MHz core clock and an apb slave with 32-bit data
`default_nettype none

package sswd_pkg;

	// clock and filter timing
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned GLITCH_NS = 55000;
	// least time, rounded up
	localparam int unsigned GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned MR_REJECT_NS = 200;
	localparam int unsigned MR_FILT_CYC = (MR_REJECT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYC_DEF = TICK_NS * CLK_MHZ / 1000;
	localparam int unsigned RUN_W = 12;

	// register map, byte addresses
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	// control fields
	localparam int unsigned CTRL_HOLD_LSB = 0;
	localparam int unsigned CTRL_WD_LSB = 4;
	localparam logic [2:0] HOLD_OPT_RST = 3'h2;
	localparam logic [1:0] WD_OPT_RST = 2'h0;
	localparam logic [10:0] HOLD_MS_RST = 11'h0E1; // 225 ms
	// status fields
	localparam int unsigned STAT_RST = 0;
	localparam int unsigned STAT_SUP = 1;
	localparam int unsigned STAT_MAN = 2;
	localparam int unsigned STAT_WDDIS = 3;
	localparam int unsigned STAT_LINE = 4;
	localparam int unsigned STAT_CNT_LSB = 16;

	// pin synchroniser lanes, with idle levels at reset
	localparam int unsigned PIN_SUP = 0;
	localparam int unsigned PIN_MAN = 1;
	localparam int unsigned PIN_KICK = 2;
	localparam int unsigned PIN_WDD = 3;
	localparam int unsigned PIN_LINE = 4;
	localparam int unsigned PIN_N = 5;
	localparam logic [4:0] PIN_IDLE = 5'h12;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ASSERT = 2'b01,
		ST_HOLD = 2'b11
	} sswd_state_e;

	// hold period in ms for each factory option
	function automatic logic [10:0] hold_ms(input logic [2:0] opt);
		case (opt)
			3'h0: hold_ms = 11'h00F; // 15
			3'h1: hold_ms = 11'h03C; // 60
			3'h2: hold_ms = 11'h0E1; // 225
			3'h3: hold_ms = 11'h1C2; // 450
			3'h4: hold_ms = 11'h384; // 900
			default: hold_ms = 11'h708; // 1800, also codes 5..7
		endcase
	endfunction : hold_ms

	// watchdog timeout in ms for each factory option
	function automatic logic [14:0] wd_ms(input logic [1:0] opt);
		case (opt)
			2'h0: wd_ms = 15'h0CE4; // 3.3 s
			2'h1: wd_ms = 15'h1770; // 6 s
			2'h2: wd_ms = 15'h2EE0; // 12 s
			default: wd_ms = 15'h5DC0; // 24 s
		endcase
	endfunction : wd_ms

endpackage : sswd_pkg

`default_nettype wire

// ==== sswd_wd_if.sv ====
// link between the reset sequencer and the watchdog counter
// assumes both ends run on the same core clock
`default_nettype none

interface sswd_wd_if;
	logic tick; // 1 ms timebase pulse
	logic kick; // one-cycle kick pulse
	logic hold; // keep counter cleared
	logic [1:0] opt; // timeout option
	logic expire; // one-cycle timeout pulse
	logic [14:0] count; // elapsed ms

	modport ctrl (output tick, kick, hold, opt, input expire, count);
	modport wdog (input tick, kick, hold, opt, output expire, count);
endinterface : sswd_wd_if

`default_nettype wire

// ==== sswd_wdog.sv ====
// watchdog counter: counts ms ticks, cleared by kick or hold
// assumes tick, kick and hold come from logic on the same clock
`default_nettype none

module sswd_wdog
	import sswd_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	sswd_wd_if.wdog wd // sequencer side
);

	logic [14:0] cnt_r;
	logic [14:0] cnt_nxt;
	logic exp_r;
	logic exp_nxt;

	// clear on hold or kick, else count ticks up to the timeout
	always_comb
	begin
		cnt_nxt = cnt_r;
		exp_nxt = 1'b0;
		if (wd.hold || wd.kick)
			cnt_nxt = 15'h0000;
		else if (wd.tick)
		begin
			if (cnt_r + 15'h0001 >= wd_ms(wd.opt))
			begin
				cnt_nxt = 15'h0000;
				exp_nxt = 1'b1;
			end
			else
				cnt_nxt = cnt_r + 15'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= 15'h0000;
			exp_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign wd.count = cnt_r;
	assign wd.expire = exp_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_hold_clears: assert property (
		wd.hold |=> cnt_r == 15'h0000 && !exp_r)
		else $error("watchdog advanced while held");
	a_kick_clears: assert property (
		wd.kick && !wd.hold |=> cnt_r == 15'h0000)
		else $error("kick did not clear watchdog");
	a_count_restart: assert property (
		$fell(wd.hold) |-> cnt_r == 15'h0000 ##1 cnt_r <= 15'h0001)
		else $error("watchdog did not restart from zero");
	c_wd_timeout: cover property (exp_r);

endmodule : sswd_wdog

`default_nettype wire

// ==== sswd_top.sv ====
// supply supervisor with manual reset and watchdog, apb control
// assumes pins are asynchronous; apb runs on CORE_CLK
//
// Behaviour
// - supply low asserts reset: high output high, low outputs low
// - after supply low clears, reset stays for the hold period
// - reset at power-up, power-down, brownout, all with hold extension
// - supply dips shorter than 55us do not start a reset
// - kick input detects level changes as short as 150ns
// - watchdog timeout option: 3.3 s, 6 s, 12 s or 24 s
// - watchdog expiry asserts reset for the hold period
// - watchdog held at zero while reset is asserted
// - watchdog counts from zero once reset deasserts
// - watchdog cleared by reset or any kick toggle
// - disable input high stops and clears the watchdog
// - manual low asserts reset, then hold period after release
// - unconnected manual input reads high, so inactive; here only the synchroniser reset level is high, no pull-up
// - manual switch bounce gives no extra reset sequences
// - hold period option: 15, 60, 225, 450, 900 or 1800 ms
// - open-drain output only pulls the reset line low
`default_nettype none

module sswd_top
	import sswd_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF // cycles per ms
)
(
	input wire logic CORE_CLK, // core clock, 40 MHz
	input wire logic RESET_N, // async reset, active low
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb enable
	input wire logic PWRITE, // apb direction
	input wire logic [11:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error
	input wire logic SUPPLY_LOW_IN, // comparator, high = undervoltage
	input wire logic MANUAL_RST_LOW_IN, // manual reset, active low
	input wire logic WATCHDOG_KICK_IN, // kick toggle from host
	input wire logic WATCHDOG_DISABLE_IN, // high stops watchdog
	output logic RST_ACTIVE_HIGH_OUT, // push-pull, high = reset
	output logic SYS_RST_ACTIVE_LOW_OUT, // push-pull, low = reset
	output logic RST_OD_O, // open-drain data, always low
	output logic RST_OD_OE_N, // open-drain enable, low = pull
	input wire logic RST_OD_I // shared reset line level
);

	sswd_wd_if wd ();

	sswd_wdog u_wdog (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.wd(wd)
	);

	// two-flop synchronisers for every pin
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] sync1_r;
	logic [PIN_N-1:0] sync2_r;
	logic kick_d_r;
	logic kick_p;

	assign pin_raw = {RST_OD_I, WATCHDOG_DISABLE_IN, WATCHDOG_KICK_IN,
		MANUAL_RST_LOW_IN, SUPPLY_LOW_IN};

	// idle levels keep the manual lane inactive only until the pins are first sampled after reset
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			sync1_r <= PIN_IDLE;
			sync2_r <= PIN_IDLE;
			kick_d_r <= 1'b0;
		end
		else
		begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
			kick_d_r <= sync2_r[PIN_KICK];
		end
	end

	// any change of the synced kick level, either edge
	assign kick_p = sync2_r[PIN_KICK] ^ kick_d_r;

	// run-length count of an active level, saturating at lim
	function automatic logic [RUN_W-1:0] run_next(input logic [RUN_W-1:0] run,
		input logic act, input logic [RUN_W-1:0] lim);
		if (!act)
			run_next = '0;
		else if (run == lim)
			run_next = run;
		else
			run_next = run + 1'b1;
	endfunction : run_next

	// glitch and bounce filters
	localparam logic [RUN_W-1:0] SUP_LIM = RUN_W'(GLITCH_CYC);
	localparam logic [RUN_W-1:0] MAN_LIM = RUN_W'(MR_FILT_CYC);
	logic [RUN_W-1:0] sup_run_r;
	logic [RUN_W-1:0] sup_run_nxt;
	logic [RUN_W-1:0] man_run_r;
	logic [RUN_W-1:0] man_run_nxt;
	logic sup_f_r;
	logic sup_f_nxt;
	logic man_f_r;
	logic man_f_nxt;

	// a dip must last the whole glitch window before it counts
	always_comb
	begin
		sup_run_nxt = run_next(sup_run_r, sync2_r[PIN_SUP], SUP_LIM);
		man_run_nxt = run_next(man_run_r, !sync2_r[PIN_MAN], MAN_LIM);
		sup_f_nxt = sup_run_nxt == SUP_LIM;
		// short rejection keeps a 1us press well inside detection
		man_f_nxt = man_run_nxt == MAN_LIM;
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			sup_run_r <= '0;
			man_run_r <= '0;
			sup_f_r <= 1'b0;
			man_f_r <= 1'b0;
		end
		else
		begin
			sup_run_r <= sup_run_nxt;
			man_run_r <= man_run_nxt;
			sup_f_r <= sup_f_nxt;
			man_f_r <= man_f_nxt;
		end
	end

	// control register
	logic [2:0] hold_opt_r;
	logic [2:0] hold_opt_nxt;
	logic [1:0] wd_opt_r;
	logic [1:0] wd_opt_nxt;

	// reset sequencer
	sswd_state_e st_r;
	sswd_state_e st_nxt;
	logic [10:0] hold_cnt_r;
	logic [10:0] hold_cnt_nxt;
	logic [10:0] hold_lim_r;
	logic [10:0] hold_lim_nxt;
	logic [31:0] pre_r;
	logic [31:0] pre_nxt;
	logic tick;
	logic src;

	assign tick = pre_r == TICK_CYC - 1;
	// all sources share one hold counter
	assign src = sup_f_r | man_f_r | wd.expire;

	// any active source restarts the hold from full length
	always_comb
	begin
		st_nxt = st_r;
		hold_cnt_nxt = hold_cnt_r;
		hold_lim_nxt = hold_lim_r;
		pre_nxt = tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
		if (src)
		begin
			// bounce only reloads the hold, never a second sequence
			st_nxt = ST_ASSERT;
			hold_cnt_nxt = hold_ms(hold_opt_r);
			hold_lim_nxt = hold_ms(hold_opt_r);
			pre_nxt = 32'h0000_0000;
		end
		else
		begin
			case (st_r)
				ST_ASSERT:
				begin
					st_nxt = ST_HOLD;
					pre_nxt = 32'h0000_0000;
				end
				ST_HOLD:
				begin
					if (tick)
					begin
						hold_cnt_nxt = hold_cnt_r - 11'h001;
						if (hold_cnt_r == 11'h001)
							st_nxt = ST_IDLE;
					end
				end
				ST_IDLE: st_nxt = ST_IDLE;
				default: st_nxt = ST_HOLD;
			endcase
		end
	end

	// power-up starts in the hold state with the default period
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			st_r <= ST_HOLD;
			hold_cnt_r <= HOLD_MS_RST;
			hold_lim_r <= HOLD_MS_RST;
			pre_r <= 32'h0000_0000;
		end
		else
		begin
			st_r <= st_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			hold_lim_r <= hold_lim_nxt;
			pre_r <= pre_nxt;
		end
	end

	// watchdog held while reset is out or disable is high
	assign wd.tick = tick;
	assign wd.kick = kick_p;
	assign wd.hold = (st_r != ST_IDLE) | sync2_r[PIN_WDD];
	assign wd.opt = wd_opt_r;

	// reset outputs, registered from the next state
	logic rst_act_nxt;
	logic rst_hi_r;
	logic rst_lo_r;

	assign rst_act_nxt = st_nxt != ST_IDLE;

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rst_hi_r <= 1'b1;
			rst_lo_r <= 1'b0;
		end
		else
		begin
			rst_hi_r <= rst_act_nxt;
			rst_lo_r <= !rst_act_nxt;
		end
	end

	assign RST_ACTIVE_HIGH_OUT = rst_hi_r;
	assign SYS_RST_ACTIVE_LOW_OUT = rst_lo_r;
	// open drain never drives high, so a cpu can share the line
	assign RST_OD_O = 1'b0;
	assign RST_OD_OE_N = rst_lo_r;

	// apb slave: ready in the first access cycle, no wait states
	logic setup;
	logic mapped;
	logic wr_ok;
	logic [31:0] rd_val;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pslverr_r;
	logic pslverr_nxt;

	assign setup = PSEL && !PENABLE;
	assign mapped = PADDR == ADDR_CTRL || PADDR == ADDR_STAT;
	assign wr_ok = PSEL && PENABLE && pready_r && PWRITE && !pslverr_r &&
		PADDR == ADDR_CTRL;

	// read mux and control write; unmapped gives pslverr, reads zero
	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (PADDR == ADDR_CTRL)
		begin
			rd_val[CTRL_HOLD_LSB +: 3] = hold_opt_r;
			rd_val[CTRL_WD_LSB +: 2] = wd_opt_r;
		end
		else if (PADDR == ADDR_STAT)
		begin
			rd_val[STAT_RST] = st_r != ST_IDLE;
			rd_val[STAT_SUP] = sup_f_r;
			rd_val[STAT_MAN] = man_f_r;
			rd_val[STAT_WDDIS] = sync2_r[PIN_WDD];
			rd_val[STAT_LINE] = sync2_r[PIN_LINE];
			rd_val[STAT_CNT_LSB +: 15] = wd.count;
		end
		prdata_nxt = (setup && !PWRITE) ? rd_val : prdata_r;
		pslverr_nxt = setup && !mapped;
		hold_opt_nxt = wr_ok ? PWDATA[CTRL_HOLD_LSB +: 3] : hold_opt_r;
		wd_opt_nxt = wr_ok ? PWDATA[CTRL_WD_LSB +: 2] : wd_opt_r;
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			hold_opt_r <= HOLD_OPT_RST;
			wd_opt_r <= WD_OPT_RST;
		end
		else
		begin
			prdata_r <= prdata_nxt;
			pready_r <= setup;
			pslverr_r <= pslverr_nxt;
			hold_opt_r <= hold_opt_nxt;
			wd_opt_r <= wd_opt_nxt;
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;

	// helper: cycles spent in the hold state
	logic [31:0] hold_cyc_r;

	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			hold_cyc_r <= 32'h0000_0000;
		else
			hold_cyc_r <= (st_r == ST_HOLD) ? hold_cyc_r + 32'h0000_0001 :
				32'h0000_0000;
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);

	a_supply_asserts: assert property (
		sup_f_r |=> RST_ACTIVE_HIGH_OUT && !SYS_RST_ACTIVE_LOW_OUT)
		else $error("supply low did not assert reset");
	a_hold_length: assert property (
		st_r == ST_HOLD && st_nxt == ST_IDLE && hold_cyc_r != 32'h0000_0000
		|-> hold_cyc_r == 32'(hold_lim_r) * 32'(TICK_CYC) - 32'h0000_0001)
		else $error("hold period length wrong");
	a_glitch_ignored: assert property (
		!sup_f_r && sup_run_r < SUP_LIM - 1'b1 |=> !sup_f_r)
		else $error("short supply dip started a reset");
	a_wd_reset: assert property (
		wd.expire |=> RST_ACTIVE_HIGH_OUT [*2])
		else $error("watchdog expiry did not assert reset");
	a_manual_asserts: assert property (
		man_f_r |=> !SYS_RST_ACTIVE_LOW_OUT)
		else $error("manual reset not asserted");
	a_manual_idle: assert property (
		sync2_r[PIN_MAN] |=> !man_f_r)
		else $error("high manual input seen as active");
	a_od_pull_low: assert property (
		RST_OD_O == 1'b0 && RST_OD_OE_N == !RST_ACTIVE_HIGH_OUT)
		else $error("open drain drove high or wrong enable");
	a_kick_edge: assert property (
		$changed(sync2_r[PIN_KICK]) |=> wd.count == 15'h0000)
		else $error("kick edge did not clear watchdog");
	a_apb_ready: assert property (
		setup |=> PREADY ##1 !PREADY)
		else $error("apb ready not a single access cycle");

	c_supply_reset: cover property ($rose(sup_f_r));
	c_manual_reset: cover property ($rose(man_f_r));
	c_wd_expire: cover property (wd.expire ##1 st_r == ST_ASSERT);
	c_hold_done: cover property (st_r == ST_HOLD && st_nxt == ST_IDLE);

endmodule : sswd_top

`default_nettype wire

// ==== sswd_host.sv ====
// host model: kicks the watchdog and shares the open-drain reset line
// assumes the bench clock and a pull-up on the shared line
`default_nettype none

module sswd_host
(
	input wire logic clk, // bench clock
	input wire logic kick_en, // keep kicking
	input wire logic [15:0] kick_per, // cycles between kicks
	input wire logic host_pull, // host drives line low
	input wire logic od_o, // device open-drain data
	input wire logic od_oe_n, // device enable, low = pull
	output var logic kick, // kick pin
	output wire logic line // shared reset line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt = 16'h0000;
	logic was_en = 1'b0;
	// pull-up wins unless a party pulls low
	assign line = ~host_pull & (od_oe_n | od_o);
	initial kick = 1'b0;
	// toggle well inside the timeout; one last toggle when stopped
	always @(posedge clk)
	begin
		was_en <= kick_en;
		cnt <= kick_en ? cnt + 16'h0001 : 16'h0000;
		if ((kick_en && cnt >= kick_per) || (was_en && !kick_en))
		begin
			kick <= ~kick;
			cnt <= 16'h0000;
		end
	end
endmodule : sswd_host

`default_nettype wire

// ==== supply_supervisor_watchdog_tb.sv ====
// self-checking bench for the supply supervisor top
// assumes TICK_CYC of 4, so one ms is four cycles of 25 ns
`default_nettype none

module supply_supervisor_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sswd_pkg::*;
	typedef struct packed
	{
		logic [11:0] a;
		logic w;
		logic [31:0] d;
		logic [31:0] q;
		logic e;
	} sswd_row_s;
	localparam int CEIL = 95000;
	logic CORE_CLK = 1'b0, RESET_N = 1'b0;
	logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA, q;
	logic PREADY, PSLVERR, e, prev = 1'b0;
	logic SUPPLY_LOW_IN = 1'b0, MANUAL_RST_LOW_IN = 1'b1;
	logic WATCHDOG_DISABLE_IN = 1'b0, kick, line, od_o, od_oe_n;
	logic RST_ACTIVE_HIGH_OUT, SYS_RST_ACTIVE_LOW_OUT;
	logic kick_en = 1'b0, host_pull = 1'b0;
	int fails = 0, tests_run = 0, cyc = 0, rises = 0, n, r0;
	int hms[6] = '{15, 60, 225, 450, 900, 1800};
	sswd_row_s rows[7] = '{
		'{12'h000, 1'b0, 32'h0, 32'h0000_0002, 1'b0},
		'{12'h000, 1'b1, 32'h0000_0031, 32'h0, 1'b0},
		'{12'h000, 1'b0, 32'h0, 32'h0000_0031, 1'b0},
		'{12'h004, 1'b1, 32'hFFFF_FFFF, 32'h0, 1'b0},
		'{12'h008, 1'b0, 32'h0, 32'h0, 1'b1},
		'{12'h00C, 1'b1, 32'h0000_0005, 32'h0, 1'b1},
		'{12'h000, 1'b0, 32'h0, 32'h0000_0031, 1'b0}};

	sswd_top #(.TICK_CYC(4)) sswd_top_i (.CORE_CLK(CORE_CLK),
		.RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SUPPLY_LOW_IN(SUPPLY_LOW_IN),
		.MANUAL_RST_LOW_IN(MANUAL_RST_LOW_IN),
		.WATCHDOG_KICK_IN(kick),
		.WATCHDOG_DISABLE_IN(WATCHDOG_DISABLE_IN),
		.RST_ACTIVE_HIGH_OUT(RST_ACTIVE_HIGH_OUT),
		.SYS_RST_ACTIVE_LOW_OUT(SYS_RST_ACTIVE_LOW_OUT),
		.RST_OD_O(od_o), .RST_OD_OE_N(od_oe_n), .RST_OD_I(line));
	sswd_host sswd_host_i (.clk(CORE_CLK), .kick_en(kick_en),
		.kick_per(16'h03E8), .host_pull(host_pull), .od_o(od_o),
		.od_oe_n(od_oe_n), .kick(kick), .line(line));

	// clock, hang guard and count of reset sequences
	always #12.5 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK)
	begin
		cyc <= cyc + 1;
		prev <= RST_ACTIVE_HIGH_OUT;
		if (RST_ACTIVE_HIGH_OUT === 1'b1 && prev === 1'b0)
			rises <= rises + 1;
		if (cyc == CEIL)
		begin
			fails++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: saw %h not %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; held until pready is seen at an edge
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] rq, output logic re);
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		// no local limit: only the bench timeout ends a stuck wait
		do
		begin
			@(posedge CORE_CLK);
		end
		while (PREADY !== 1'b1);
		rq = PRDATA;
		re = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	// cycles until the active-high reset reaches lvl, capped at max
	task automatic wait_lvl(input logic lvl, input int max, output int c);
		c = 0;
		while (RST_ACTIVE_HIGH_OUT !== lvl && c < max)
		begin
			@(posedge CORE_CLK);
			c++;
		end
	endtask : wait_lvl

	function automatic logic [31:0] inwin(input int c, lo, hi);
		return {31'h0, c >= lo && c <= hi};
	endfunction : inwin

	function automatic logic [31:0] outs();
		return {28'h0, RST_ACTIVE_HIGH_OUT, SYS_RST_ACTIVE_LOW_OUT,
			od_oe_n, od_o};
	endfunction : outs

	task final_report();
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	initial
	begin
		// power-up reset, then the default 225 ms hold
		repeat (8) @(posedge CORE_CLK);
		check(outs(), 32'h8);
		RESET_N <= 1'b1;
		wait_lvl(1'b0, 1000, n);
		check(inwin(n, 900, 930), 1);
		check(outs(), 32'h6);
		// register rows through one loop
		foreach (rows[i])
		begin
			apb(rows[i].a, rows[i].w, rows[i].d, q, e);
			check(e, rows[i].e);
			if (!rows[i].w)
				check(q, rows[i].q);
		end
		// shared line read back while the host pulls it
		host_pull <= 1'b1;
		// let the line level pass the two-flop synchroniser first
		repeat (2) @(posedge CORE_CLK);
		apb(ADDR_STAT, 1'b0, 32'h0, q, e);
		check(q[STAT_LINE], 1'b0);
		host_pull <= 1'b0;
		// manual press of 1 us against every hold option
		for (int i = 0; i < 6; i++)
		begin
			apb(ADDR_CTRL, 1'b1, i, q, e);
			MANUAL_RST_LOW_IN <= 1'b0;
			repeat (40) @(posedge CORE_CLK);
			check(outs(), 32'h8);
			MANUAL_RST_LOW_IN <= 1'b1;
			wait_lvl(1'b0, 8000, n);
			check(inwin(n, hms[i] * 4, hms[i] * 4 + 24), 1);
		end
		apb(ADDR_CTRL, 1'b1, 32'h0000_0002, q, e);
		// bouncing switch gives one reset sequence
		r0 = rises;
		for (int i = 0; i < 4; i++)
		begin
			MANUAL_RST_LOW_IN <= 1'b0;
			repeat (3) @(posedge CORE_CLK);
			MANUAL_RST_LOW_IN <= 1'b1;
			repeat (3) @(posedge CORE_CLK);
		end
		MANUAL_RST_LOW_IN <= 1'b0;
		repeat (40) @(posedge CORE_CLK);
		MANUAL_RST_LOW_IN <= 1'b1;
		repeat (5) @(posedge CORE_CLK);
		MANUAL_RST_LOW_IN <= 1'b0;
		repeat (40) @(posedge CORE_CLK);
		MANUAL_RST_LOW_IN <= 1'b1;
		wait_lvl(1'b0, 1200, n);
		check(rises - r0, 1);
		// short supply dip ignored, long one resets
		SUPPLY_LOW_IN <= 1'b1;
		repeat (2100) @(posedge CORE_CLK);
		SUPPLY_LOW_IN <= 1'b0;
		wait_lvl(1'b1, 300, n);
		check(n, 300);
		SUPPLY_LOW_IN <= 1'b1;
		wait_lvl(1'b1, 2400, n);
		check(inwin(n, 2200, 2215), 1);
		SUPPLY_LOW_IN <= 1'b0;
		wait_lvl(1'b0, 1000, n);
		check(inwin(n, 900, 930), 1);
		// kicked watchdog stays quiet, then expires after 3.3 s
		kick_en <= 1'b1;
		wait_lvl(1'b1, 20000, n);
		check(n, 20000);
		kick_en <= 1'b0;
		wait_lvl(1'b1, 14000, n);
		check(inwin(n, 13190, 13230), 1);
		check(outs(), 32'h8);
		apb(ADDR_STAT, 1'b0, 32'h0, q, e);
		check(q[30:16], 15'h0000);
		wait_lvl(1'b0, 1000, n);
		check(inwin(n, 880, 930), 1);
		apb(ADDR_STAT, 1'b0, 32'h0, q, e);
		check(q[30:16] <= 15'h0001, 1);
		// disable input holds the watchdog cleared
		WATCHDOG_DISABLE_IN <= 1'b1;
		wait_lvl(1'b1, 14000, n);
		check(n, 14000);
		apb(ADDR_STAT, 1'b0, 32'h0, q, e);
		check({q[STAT_WDDIS], q[30:16]}, 16'h8000);
		final_report();
	end
endmodule : supply_supervisor_watchdog_tb

`default_nettype wire
